/* hdl/cair_consts.svh */
// constants for the accumulator and index register block
`ifndef CAIR_CONSTS_SVH
`define CAIR_CONSTS_SVH
`define CAIR_ADDR_W      16
`define CAIR_BYTE_W      8
`define CAIR_WORD_W      16
`define CAIR_ACC_RST     8'h00
`define CAIR_IDX_RST     16'h0000
`define CAIR_FLAG_RST    8'hd0
`define CAIR_RF_DEPTH    4
`define CAIR_RF_AW       2
`define CAIR_SEL_ACC_A   2'h0
`define CAIR_SEL_ACC_B   2'h1
`define CAIR_SEL_IDX_X   2'h2
`define CAIR_SEL_IDX_Y   2'h3
`define CAIR_IDX_EXTRA   1
`define CAIR_FLAG_C      0
`define CAIR_FLAG_V      1
`define CAIR_FLAG_Z      2
`define CAIR_FLAG_N      3
`define CAIR_FLAG_H      5
`endif

/* hdl/cair_pkg.sv */
// types for the accumulator and index register block
package cair_pkg;
    // register operations
    typedef enum logic [3:0] {
        CAIR_OP_NONE        = 4'h0,
        CAIR_OP_LOAD        = 4'h1,
        CAIR_OP_LOAD_D      = 4'h2,
        CAIR_OP_ADD_B_IDX   = 4'h3,
        CAIR_OP_MOVE_FLAGS  = 4'h4,
        CAIR_OP_LOAD_FLAGS  = 4'h5,
        CAIR_OP_DEC_ADJ     = 4'h6,
        CAIR_OP_ADD_BA      = 4'h7,
        CAIR_OP_SUB_BA      = 4'h8,
        CAIR_OP_CMP_AB      = 4'h9,
        CAIR_OP_IDX_INC     = 4'ha,
        CAIR_OP_IDX_DEC     = 4'hb,
        CAIR_OP_EFF_ADDR    = 4'hc
    } cair_op_t;
    // answer timing state
    typedef enum logic [1:0] {
        CAIR_ST_IDLE = 2'b00,
        CAIR_ST_WAIT = 2'b01,
        CAIR_ST_DONE = 2'b10
    } cair_state_t;
endpackage : cair_pkg

/* hdl/cair_rf.sv */
// small register storage for accumulators and index registers
`timescale 1ns/1ps
`include "cair_consts.svh"
module cair_rf
(
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rstn,
    // write port
    input  wire logic                     wr_en,
    input  wire logic [`CAIR_RF_AW-1:0]   wr_sel,
    input  wire logic [`CAIR_WORD_W-1:0]  wr_data,
    // all entries, registered
    output logic      [`CAIR_WORD_W-1:0]  rd_word [`CAIR_RF_DEPTH]
);
    // next value of each entry
    logic [`CAIR_WORD_W-1:0] next_word [`CAIR_RF_DEPTH];

    // one entry per generate step
    genvar gi;
    generate
        for (gi = 0; gi < `CAIR_RF_DEPTH; gi++)
        begin : g_ent
            // next value: write or hold
            always_comb
            begin
                next_word[gi] = rd_word[gi];
                if (wr_en && wr_sel == (`CAIR_RF_AW)'(gi))
                    next_word[gi] = wr_data;
            end
            // register only
            always_ff @(posedge mclk)
            begin
                if (!rstn)
                    rd_word[gi] <= `CAIR_IDX_RST;
                else
                    rd_word[gi] <= next_word[gi];
            end
        end
    endgenerate

    // a write shows up in its entry on the next edge
    property p_wr_lands;
        @(posedge mclk) disable iff (!rstn)
            wr_en |=> rd_word[$past(wr_sel)] == $past(wr_data);
    endproperty
    a_wr_lands: assert property (p_wr_lands) else $error("write lost");

    // second accumulator holds unless written
    property p_b_holds;
        @(posedge mclk) disable iff (!rstn)
            !(wr_en && wr_sel == `CAIR_SEL_ACC_B)
            |=> $stable(rd_word[`CAIR_SEL_ACC_B]);
    endproperty
    a_b_holds: assert property (p_b_holds) else $error("b changed");
endmodule : cair_rf

/* hdl/cair_regs.sv */
// cpu accumulator and index register set with its asymmetric operations
`timescale 1ns/1ps
`include "cair_consts.svh"
module cair_regs
    import cair_pkg::*;
(
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rstn,
    // operation request
    input  wire logic                     op_valid,
    input  wire cair_op_t                 op_code,
    input  wire logic [1:0]               op_sel,
    input  wire logic [`CAIR_WORD_W-1:0]  op_data,
    input  wire logic                     op_ext_mem,
    // operation answer
    output logic                          op_done,
    output logic                          op_busy,
    // register views
    output logic [`CAIR_BYTE_W-1:0]       acc_a,
    output logic [`CAIR_BYTE_W-1:0]       acc_b,
    output logic [`CAIR_WORD_W-1:0]       acc_d,
    output logic [`CAIR_WORD_W-1:0]       first_index_reg,
    output logic [`CAIR_WORD_W-1:0]       second_index_reg,
    output logic [`CAIR_BYTE_W-1:0]       flag_register,
    output logic [`CAIR_ADDR_W-1:0]       eff_addr
);
    // storage entries
    logic [`CAIR_WORD_W-1:0] rf_word [`CAIR_RF_DEPTH];
    // storage write port
    logic                    rf_wr;
    logic [`CAIR_RF_AW-1:0]  rf_sel;
    logic [`CAIR_WORD_W-1:0] rf_data;
    // second write for the pair
    logic                    pair_wr;
    logic [`CAIR_BYTE_W-1:0] pair_lo;
    // low byte waiting for the write port
    logic [`CAIR_BYTE_W-1:0] lo_hold;
    logic                    lo_pend;
    // flags and answer state
    logic [`CAIR_BYTE_W-1:0] next_flags;
    cair_state_t             state;
    cair_state_t             next_state;
    logic                    next_done;
    logic [`CAIR_ADDR_W-1:0] next_eff;
    // held request
    cair_op_t                hold_op;
    logic [1:0]              hold_sel;
    logic [`CAIR_WORD_W-1:0] hold_data;
    cair_op_t                next_hold_op;
    logic [1:0]              next_hold_sel;
    logic [`CAIR_WORD_W-1:0] next_hold_data;
    // byte views
    logic [`CAIR_BYTE_W-1:0] a_now;
    logic [`CAIR_BYTE_W-1:0] b_now;
    // alu scratch
    logic [`CAIR_BYTE_W:0]   sum9;
    logic [`CAIR_WORD_W:0]   sum17;
    logic [`CAIR_BYTE_W-1:0] adj;
    logic                    adj_c;
    logic                    do_op;
    cair_op_t                eop;
    logic [1:0]              esel;
    logic [`CAIR_WORD_W-1:0] edata;

    // internal storage, write select decoded per entry inside cair_rf
    cair_rf u_rf
    (
        .mclk    (mclk),
        .rstn    (rstn),
        .wr_en   (rf_wr),
        .wr_sel  (rf_sel),
        .wr_data (rf_data),
        .rd_word (rf_word)
    );

    assign a_now = rf_word[`CAIR_SEL_ACC_A][`CAIR_BYTE_W-1:0];
    assign b_now = rf_word[`CAIR_SEL_ACC_B][`CAIR_BYTE_W-1:0];

    // answer timing: second index load, step and address wait one cycle
    always_comb
    begin
        next_state     = state;
        next_done      = 1'b0;
        next_hold_op   = hold_op;
        next_hold_sel  = hold_sel;
        next_hold_data = hold_data;
        do_op          = 1'b0;
        eop            = op_code;
        esel           = op_sel;
        edata          = op_data;
        case (state)
            CAIR_ST_IDLE:
            begin
                if (op_valid && !lo_pend)
                begin
                    // external operand: no extra wait
                    if ((op_sel[0] &&
                         (op_code == CAIR_OP_EFF_ADDR ||
                          op_code == CAIR_OP_IDX_INC ||
                          op_code == CAIR_OP_IDX_DEC)) ||
                        (op_sel == `CAIR_SEL_IDX_Y &&
                         op_code == CAIR_OP_LOAD))
                    begin
                        next_state     = CAIR_ST_WAIT;
                        next_hold_op   = op_code;
                        next_hold_sel  = op_sel;
                        next_hold_data = op_data;
                    end
                    else
                    begin
                        do_op     = 1'b1;
                        next_done = 1'b1;
                    end
                end
            end
            CAIR_ST_WAIT:
            begin
                do_op      = 1'b1;
                eop        = hold_op;
                esel       = hold_sel;
                edata      = hold_data;
                next_done  = 1'b1;
                next_state = CAIR_ST_IDLE;
            end
            default:
                next_state = CAIR_ST_IDLE;
        endcase
    end

    // datapath: one write port, pair writes its low byte on the next cycle
    always_comb
    begin
        rf_wr      = 1'b0;
        rf_sel     = esel;
        rf_data    = edata;
        pair_wr    = 1'b0;
        pair_lo    = edata[`CAIR_BYTE_W-1:0];
        next_flags = flag_register;
        next_eff   = eff_addr;
        sum9       = '0;
        sum17      = '0;
        adj        = 8'h00;
        adj_c      = 1'b0;
        if (do_op)
        begin
            case (eop)
                CAIR_OP_LOAD:
                begin
                    rf_wr = 1'b1;
                    if (esel <= `CAIR_SEL_ACC_B)
                        rf_data = {8'h00, edata[`CAIR_BYTE_W-1:0]};
                end
                CAIR_OP_LOAD_D:
                begin
                    // upper byte to first, lower to second
                    rf_wr   = 1'b1;
                    rf_sel  = `CAIR_SEL_ACC_A;
                    rf_data = {8'h00, edata[`CAIR_WORD_W-1:`CAIR_BYTE_W]};
                    pair_wr = 1'b1;
                end
                CAIR_OP_ADD_B_IDX:
                begin
                    // second accumulator only, unsigned
                    rf_wr   = 1'b1;
                    rf_sel  = esel[0] ? `CAIR_SEL_IDX_Y : `CAIR_SEL_IDX_X;
                    rf_data = rf_word[rf_sel] + {8'h00, b_now};
                end
                CAIR_OP_MOVE_FLAGS:
                begin
                    rf_wr   = 1'b1;
                    rf_sel  = `CAIR_SEL_ACC_A;
                    rf_data = {8'h00, flag_register};
                end
                CAIR_OP_LOAD_FLAGS:
                    next_flags = a_now;
                CAIR_OP_DEC_ADJ:
                begin
                    // bcd correction of first accumulator
                    if (flag_register[`CAIR_FLAG_H] || a_now[3:0] > 4'h9)
                        adj[3:0] = 4'h6;
                    if (flag_register[`CAIR_FLAG_C] || a_now > 8'h99)
                    begin
                        adj[7:4] = 4'h6;
                        adj_c    = 1'b1;
                    end
                    sum9    = {1'b0, a_now} + {1'b0, adj};
                    rf_wr   = 1'b1;
                    rf_sel  = `CAIR_SEL_ACC_A;
                    rf_data = {8'h00, sum9[`CAIR_BYTE_W-1:0]};
                    next_flags[`CAIR_FLAG_C] = adj_c;
                    next_flags[`CAIR_FLAG_Z] = (sum9[7:0] == 8'h00);
                    next_flags[`CAIR_FLAG_N] = sum9[7];
                end
                CAIR_OP_ADD_BA, CAIR_OP_SUB_BA, CAIR_OP_CMP_AB:
                begin
                    // b into a for add and subtract, compare writes no register, never reversed
                    if (eop == CAIR_OP_ADD_BA)
                        sum9 = {1'b0, a_now} + {1'b0, b_now};
                    else
                        sum9 = {1'b0, a_now} - {1'b0, b_now};
                    rf_wr   = (eop != CAIR_OP_CMP_AB);
                    rf_sel  = `CAIR_SEL_ACC_A;
                    rf_data = {8'h00, sum9[`CAIR_BYTE_W-1:0]};
                    next_flags[`CAIR_FLAG_C] = sum9[8];
                    next_flags[`CAIR_FLAG_Z] = (sum9[7:0] == 8'h00);
                    next_flags[`CAIR_FLAG_N] = sum9[7];
                    if (eop == CAIR_OP_ADD_BA)
                    begin
                        next_flags[`CAIR_FLAG_H] =
                            (a_now[3:0] + b_now[3:0]) > 5'h0f;
                        next_flags[`CAIR_FLAG_V] = (a_now[7] == b_now[7])
                            && (sum9[7] != a_now[7]);
                    end
                    else
                        next_flags[`CAIR_FLAG_V] = (a_now[7] != b_now[7])
                            && (sum9[7] != a_now[7]);
                end
                CAIR_OP_IDX_INC, CAIR_OP_IDX_DEC:
                begin
                    // index as counter, z only
                    rf_wr  = 1'b1;
                    rf_sel = esel[0] ? `CAIR_SEL_IDX_Y : `CAIR_SEL_IDX_X;
                    rf_data = (eop == CAIR_OP_IDX_INC) ?
                        rf_word[rf_sel] + 16'h0001 :
                        rf_word[rf_sel] - 16'h0001;
                    next_flags[`CAIR_FLAG_Z] = (rf_data == 16'h0000);
                end
                CAIR_OP_EFF_ADDR:
                begin
                    // offset plus index, wraps in 64k
                    sum17 = {1'b0, rf_word[esel[0] ? `CAIR_SEL_IDX_Y
                                                   : `CAIR_SEL_IDX_X]}
                          + {9'h000, edata[`CAIR_BYTE_W-1:0]};
                    next_eff = sum17[`CAIR_ADDR_W-1:0];
                end
                default:
                    rf_wr = 1'b0;
            endcase
        end
        // pending low byte of a pair owns the port
        if (lo_pend)
        begin
            rf_wr   = 1'b1;
            rf_sel  = `CAIR_SEL_ACC_B;
            rf_data = {8'h00, lo_hold};
        end
    end

    // registers of the answer, flags and held request
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            state         <= CAIR_ST_IDLE;
            op_done       <= 1'b0;
            flag_register <= `CAIR_FLAG_RST;
            eff_addr      <= 16'h0000;
            hold_op       <= CAIR_OP_NONE;
            hold_sel      <= 2'h0;
            hold_data     <= 16'h0000;
            lo_pend       <= 1'b0;
            lo_hold       <= 8'h00;
        end
        else
        begin
            state         <= next_state;
            op_done       <= next_done;
            flag_register <= next_flags;
            eff_addr      <= next_eff;
            hold_op       <= next_hold_op;
            hold_sel      <= next_hold_sel;
            hold_data     <= next_hold_data;
            lo_pend       <= pair_wr;
            lo_hold       <= pair_lo;
        end
    end

    // register views, pair is a over b
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            acc_a            <= `CAIR_ACC_RST;
            acc_b            <= `CAIR_ACC_RST;
            acc_d            <= 16'h0000;
            first_index_reg  <= `CAIR_IDX_RST;
            second_index_reg <= `CAIR_IDX_RST;
            op_busy          <= 1'b0;
        end
        else
        begin
            acc_a            <= a_now;
            acc_b            <= lo_pend ? lo_hold : b_now;
            acc_d            <= {a_now, lo_pend ? lo_hold : b_now};
            first_index_reg  <= rf_word[`CAIR_SEL_IDX_X];
            second_index_reg <= rf_word[`CAIR_SEL_IDX_Y];
            op_busy          <= (next_state == CAIR_ST_WAIT) || pair_wr;
        end
    end
    // answer timing and register checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_y_load;
        op_valid && state == CAIR_ST_IDLE && !lo_pend
            && op_sel == `CAIR_SEL_IDX_Y && op_code == CAIR_OP_LOAD;
    endsequence
    property p_y_wait;
        s_y_load |=> (op_busy && !op_done) ##1 op_done;
    endproperty
    a_y_wait: assert property (p_y_wait) else $error("y wait");
    property p_ext_mem;
        do_op && op_ext_mem && state == CAIR_ST_IDLE |=> op_done;
    endproperty
    a_ext_mem: assert property (p_ext_mem) else $error("ext slow");
    property p_pair;
        do_op && eop == CAIR_OP_LOAD_D |=> ##1 acc_d == $past(edata, 2);
    endproperty
    a_pair: assert property (p_pair) else $error("pair order");
    property p_daa_a;
        do_op && eop == CAIR_OP_DEC_ADJ |=> $stable(b_now);
    endproperty
    a_daa_a: assert property (p_daa_a) else $error("daa on b");
endmodule : cair_regs

/* test/cair_regs_tb_top.sv */
// self-checking bench for the accumulator and index register block
`timescale 1ns/1ps
`include "cair_consts.svh"
module cair_regs_tb_top
    import cair_pkg::*;
;
    // clock and reset
    logic                       mclk;
    logic                       rstn;
    // request side
    logic                       op_valid;
    cair_op_t                   op_code;
    logic [1:0]                 op_sel;
    logic [`CAIR_WORD_W-1:0]    op_data;
    logic                       op_ext_mem;
    // answer and views
    logic                       op_done;
    logic                       op_busy;
    logic [`CAIR_BYTE_W-1:0]    acc_a;
    logic [`CAIR_BYTE_W-1:0]    acc_b;
    logic [`CAIR_WORD_W-1:0]    acc_d;
    logic [`CAIR_WORD_W-1:0]    first_index_reg;
    logic [`CAIR_WORD_W-1:0]    second_index_reg;
    logic [`CAIR_BYTE_W-1:0]    flag_register;
    logic [`CAIR_ADDR_W-1:0]    eff_addr;
    // model state, kept masked to width
    int                         m_a, m_b, m_x, m_y, m_f, m_e;
    // bookkeeping
    int                         n_mismatch;
    int                         samples_checked;
    int                         seed;
    int                         rnd;
    // operations the random loop draws from
    cair_op_t                   ops [9];

    cair_regs cair_regs_i (
        .mclk(mclk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
        .op_sel(op_sel), .op_data(op_data), .op_ext_mem(op_ext_mem),
        .op_done(op_done), .op_busy(op_busy), .acc_a(acc_a), .acc_b(acc_b),
        .acc_d(acc_d), .first_index_reg(first_index_reg),
        .second_index_reg(second_index_reg),
        .flag_register(flag_register), .eff_addr(eff_addr));

    // free running 100 MHz clock
    always #5 mclk = ~mclk;

    // value comparison, four-state safe
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    // latency comparison in cycles
    task automatic chk_lat(input int got, input int exp);
        samples_checked++;
        if (got != exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_lat

    // accumulator, pair and index views against the model
    task automatic check_views();
        chk_val({8'h00, acc_a}, m_a[15:0]);
        chk_val({8'h00, acc_b}, m_b[15:0]);
        chk_val(acc_d, {m_a[7:0], m_b[7:0]});
        chk_val(first_index_reg, m_x[15:0]);
        chk_val(second_index_reg, m_y[15:0]);
    endtask : check_views

    // reference behaviour of one operation
    task automatic model_op(input cair_op_t c, input logic [1:0] s,
                            input logic [15:0] d);
        int idx;
        int adj;
        int cy;
        idx = s[0] ? m_y : m_x;
        case (c)
            CAIR_OP_LOAD:
                case (s)
                    2'h0: m_a = d[7:0];
                    2'h1: m_b = d[7:0];
                    2'h2: m_x = d;
                    default: m_y = d;
                endcase
            CAIR_OP_LOAD_D:     begin m_a = d[15:8]; m_b = d[7:0]; end
            CAIR_OP_ADD_B_IDX:  idx = (idx + m_b) & 16'hffff;
            CAIR_OP_MOVE_FLAGS: m_a = m_f;
            CAIR_OP_LOAD_FLAGS: m_f = m_a;
            CAIR_OP_DEC_ADJ:
            begin
                adj = (m_f[5] || m_a[3:0] > 9) ? 6 : 0;
                cy = (m_f[0] || m_a > 8'h99);
                if (cy) adj += 8'h60;
                m_a = (m_a + adj) & 8'hff;
                m_f = (m_f & 8'hf2) | cy | ((m_a == 0) << 2)
                    | ((m_a & 8'h80) >> 4);
            end
            CAIR_OP_ADD_BA:     m_a = (m_a + m_b) & 8'hff;
            CAIR_OP_SUB_BA:     m_a = (m_a - m_b) & 8'hff;
            CAIR_OP_IDX_INC:    idx = (idx + 1) & 16'hffff;
            CAIR_OP_IDX_DEC:    idx = (idx - 1) & 16'hffff;
            CAIR_OP_EFF_ADDR:   m_e = (idx + d[7:0]) & 16'hffff;
            default: ;
        endcase
        // index ops write back the picked index
        if (c inside {CAIR_OP_ADD_B_IDX, CAIR_OP_IDX_INC, CAIR_OP_IDX_DEC})
        begin
            if (s[0]) m_y = idx;
            else m_x = idx;
        end
    endtask : model_op

    // one request, wait for done, compare
    task automatic do_op(input cair_op_t c, input logic [1:0] s,
                         input logic [15:0] d);
        int lat;
        int exp_lat;
        exp_lat = ((c == CAIR_OP_LOAD && s == 2'h3) || (s[0] &&
            c inside {CAIR_OP_IDX_INC, CAIR_OP_IDX_DEC, CAIR_OP_EFF_ADDR}))
            ? 2 : 1;
        rnd = $random(seed);
        op_valid = 1'b1;
        op_code = c;
        op_sel = s;
        op_data = d;
        op_ext_mem = rnd[0];
        @(posedge mclk);
        #1 op_valid = 1'b0;
        lat = 1;
        // bounded wait for the done pulse
        while (op_done !== 1'b1 && lat < 8)
        begin
            @(posedge mclk);
            #1 lat++;
        end
        model_op(c, s, d);
        chk_lat(lat, exp_lat);
        if (c == CAIR_OP_EFF_ADDR)
            chk_val(eff_addr, m_e[15:0]);
        // views trail done by one cycle, pair low byte bypassed from lo_hold
        repeat (2) @(posedge mclk);
        #1 check_views();
    endtask : do_op

    // reset for 16 cycles and check reset values
    task automatic do_reset();
        rstn = 1'b0;
        op_valid = 1'b0;
        repeat (16) @(posedge mclk);
        #1 rstn = 1'b1;
        m_a = 0; m_b = 0; m_x = 0; m_y = 0; m_e = 0;
        m_f = 8'hd0;
        check_views();
        chk_val({8'h00, flag_register}, m_f[15:0]);
        chk_val(eff_addr, 16'h0000);
        chk_val({14'h0, op_done, op_busy}, 16'h0000);
    endtask : do_reset

    // verdict and end of run
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_mismatch,
                 samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // watchdog, run needs a few hundred cycles
    initial
    begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end

    // main sequence
    initial
    begin
        mclk = 1'b0; rstn = 1'b0; op_valid = 1'b0; op_code = CAIR_OP_NONE;
        op_sel = 2'h0; op_data = 16'h0000; op_ext_mem = 1'b0;
        n_mismatch = 0; samples_checked = 0; seed = 32'h7c19;
        ops = '{CAIR_OP_LOAD, CAIR_OP_LOAD_D, CAIR_OP_ADD_B_IDX,
                CAIR_OP_ADD_BA, CAIR_OP_SUB_BA, CAIR_OP_CMP_AB,
                CAIR_OP_IDX_INC, CAIR_OP_IDX_DEC, CAIR_OP_EFF_ADDR};
        do_reset();
        do_op(CAIR_OP_LOAD, 2'h1, 16'h0034);
        do_op(CAIR_OP_MOVE_FLAGS, 2'h1, 16'h0000);
        chk_val({8'h00, flag_register}, m_f[15:0]);
        do_op(CAIR_OP_LOAD, 2'h0, 16'h009b);
        do_op(CAIR_OP_DEC_ADJ, 2'h1, 16'h0000);
        chk_val({8'h00, flag_register}, m_f[15:0]);
        do_op(CAIR_OP_LOAD, 2'h0, 16'h00d5);
        do_op(CAIR_OP_LOAD_FLAGS, 2'h1, 16'h0000);
        chk_val({8'h00, flag_register}, m_f[15:0]);
        // carry boundary and operand direction
        do_op(CAIR_OP_LOAD_D, 2'h0, 16'h01ff);
        do_op(CAIR_OP_ADD_BA, 2'h0, 16'h0000);
        do_op(CAIR_OP_SUB_BA, 2'h0, 16'h0000);
        do_op(CAIR_OP_CMP_AB, 2'h0, 16'h0000);
        do_op(CAIR_OP_LOAD, 2'h2, 16'hffff);
        do_op(CAIR_OP_ADD_B_IDX, 2'h0, 16'h0000);
        do_op(CAIR_OP_EFF_ADDR, 2'h0, 16'h0080);
        do_op(CAIR_OP_LOAD, 2'h3, 16'h7f80);
        do_op(CAIR_OP_EFF_ADDR, 2'h1, 16'h00ff);
        // request during busy is dropped
        op_valid = 1'b1; op_code = CAIR_OP_LOAD; op_sel = 2'h3;
        op_data = 16'h1234;
        @(posedge mclk);
        #1 chk_val({15'h0, op_busy}, 16'h0001);
        op_sel = 2'h0; op_data = 16'h005a;
        @(posedge mclk);
        #1 op_valid = 1'b0;
        m_y = 16'h1234;
        repeat (3) @(posedge mclk);
        #1 check_views();
        // random mix of nine operations, no flag moves or decimal adjust
        for (int i = 0; i < 80; i++)
        begin
            rnd = $random(seed);
            do_op(ops[rnd[7:0] % 9], rnd[9:8], rnd[31:16]);
        end
        // second reset at the end of the run
        do_reset();
        report_and_stop();
    end
endmodule : cair_regs_tb_top
